// ===== hw/vpp_pkg.sv
package vpp_pkg;

  // ****************************************************************
  // Register map, byte addresses on the APB
  // ****************************************************************
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ALPHA  = 8'h04;
  localparam logic [7:0] OFS_CLIP0X = 8'h08;
  localparam logic [7:0] OFS_CLIP0Y = 8'h0c;
  localparam logic [7:0] OFS_CLIP1X = 8'h10;
  localparam logic [7:0] OFS_CLIP1Y = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          CTL_DECIM_LSB  = 0;
  localparam int          CTL_FMT_LSB    = 3;
  localparam int          CTL_LE_BIT     = 5;
  localparam int          CTL_SEL_EV_BIT = 6;
  localparam int          CTL_SEL_OD_BIT = 7;
  localparam int          CTL_DITH_A_BIT = 18;
  localparam int          CTL_DITH_B_BIT = 30;
  localparam int          POS_W          = 10;
  localparam int          CLIP_END_LSB   = 16;
  localparam int          STS_ODD_BIT    = 16;
  localparam int          STS_ALPHA_LSB  = 24;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] CLIP_RESET     = 32'h0000_0000;
  localparam logic [7:0]  ALPHA_RESET    = 8'h00;

  // ****************************************************************
  // Pixel formats, carriers and the dither thresholds
  // ****************************************************************
  localparam int         WORD_BYTES = 8;
  localparam logic [3:0] BYTES_RGBA = 4'h4;
  localparam logic [3:0] BYTES_YUV  = 4'h2;
  localparam logic [3:0] BYTES_8BIT = 4'h1;

  typedef enum logic [1:0] {FMT_RGBA, FMT_YUV, FMT_MONO, FMT_SPARE} vpp_fmt_e;

  // One 4:2:2 pair: two luma samples sharing one chroma pair
  typedef struct packed {
    logic [7:0] u;
    logic [7:0] y0;
    logic [7:0] v;
    logic [7:0] y1;
  } vpp_pair_s;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] u;
    logic [7:0] v;
  } vpp_pix_s;

  localparam logic [3:0] DITHER_M [16] = '{
    4'hc, 4'h7, 4'hb, 4'h0,
    4'ha, 4'h1, 4'hd, 4'h6,
    4'h5, 4'he, 4'h2, 4'h9,
    4'h3, 4'h8, 4'h4, 4'hf};

endpackage

// ===== hw/vpp_dither.sv
`timescale 1ns/1ns
// Reduces one colour component against a dither threshold
module vpp_dither #(
  parameter bit BLUE = 1'b0
) (
  input  wire logic [7:0] compIn,
  input  wire logic [3:0] thresh,
  output logic      [2:0] compOut
);
  import vpp_pkg::*;

  logic [6:0] scaleRg;
  logic [5:0] scaleB;
  logic [2:0] rgOut;
  logic [1:0] bOut;

  // Scale then step up when the remainder beats the threshold
  assign scaleRg = compIn[7:1] - 7'(((compIn[7:4] >> 3) >> 1));
  assign scaleB  = compIn[7:2] - 6'(((compIn[7:4] >> 2) >> 1));
  assign rgOut   = (scaleRg[3:0] > thresh) ? 3'(scaleRg[6:4] + 3'h1) : scaleRg[6:4];
  assign bOut    = (scaleB[3:0] > thresh) ? 2'(scaleB[5:4] + 2'h1) : scaleB[5:4];
  assign compOut = BLUE ? {1'b0, bOut} : rgOut;

endmodule // vpp_dither

// ===== hw/vpp_pipeline.sv
`timescale 1ns/1ns
module vpp_pipeline #(
  parameter bit CHAN_B     = 1'b0,
  parameter int LINE_STORE = 384
) (
  input  wire logic                      mclk,
  input  wire logic                      reset_n,
  input  wire logic [vpp_pkg::ADDR_W-1:0] paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      pairValid,
  input  wire vpp_pkg::vpp_pair_s        pairData,
  output logic                           pairReady,
  input  wire logic                      lineStart,
  input  wire logic                      fieldStart,
  input  wire logic                      fieldOdd,
  input  wire logic                      fieldEnd,
  output logic                           wordValid,
  output logic      [63:0]               wordData
);
  import vpp_pkg::*;

  localparam int IDX_W = $clog2(LINE_STORE);
  // Only the start and end position fields are stored; the rest reads zero
  localparam logic [31:0] CLIP_MASK = (32'((1 << POS_W) - 1) << CLIP_END_LSB)
                                    | 32'((1 << POS_W) - 1);

  // Line store must fit the position counter
  if (LINE_STORE < 2 || LINE_STORE > (1 << POS_W)) begin : g_bad_store
    $error("LINE_STORE out of range");
  end

  // ****************************************************************
  // Register file on APB
  // ****************************************************************
  logic [31:0] ctrl_reg, clip0x_reg, clip0y_reg, clip1x_reg, clip1y_reg;
  logic [7:0]  alpha_reg, alphaWork_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rdMux;
  logic        addrHit;
  logic        wrStrobe;
  logic        fieldOdd_reg;
  logic [POS_W-1:0] yCnt_reg;

  assign wrStrobe = psel & penable & pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addrHit;
  assign prdata   = prdata_reg;

  // Read decode; unmapped offsets read zero and flag an error
  always_comb begin
    rdMux   = 32'h0000_0000;
    addrHit = 1'b1;
    if (paddr == OFS_CTRL) begin
      rdMux = ctrl_reg;
    end else if (paddr == OFS_ALPHA) begin
      rdMux = {24'h00_0000, alpha_reg};
    end else if (paddr == OFS_CLIP0X) begin
      rdMux = clip0x_reg;
    end else if (paddr == OFS_CLIP0Y) begin
      rdMux = clip0y_reg;
    end else if (paddr == OFS_CLIP1X) begin
      rdMux = clip1x_reg;
    end else if (paddr == OFS_CLIP1Y) begin
      rdMux = clip1y_reg;
    end else if (paddr == OFS_STATUS) begin
      rdMux = '0;
      rdMux[POS_W-1:0]                = yCnt_reg;
      rdMux[STS_ODD_BIT]              = fieldOdd_reg;
      rdMux[STS_ALPHA_LSB +: 8]       = alphaWork_reg;
    end else begin
      addrHit = 1'b0;
    end
  end

  // Read data is caught in the setup phase so it is a flop in the access phase
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_reg <= rdMux;
    end
  end

  // Writable registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg   <= CTRL_RESET;
      alpha_reg  <= ALPHA_RESET;
      clip0x_reg <= CLIP_RESET;
      clip0y_reg <= CLIP_RESET;
      clip1x_reg <= CLIP_RESET;
      clip1y_reg <= CLIP_RESET;
    end else if (wrStrobe) begin
      if (paddr == OFS_CTRL)   ctrl_reg   <= pwdata;
      if (paddr == OFS_ALPHA)  alpha_reg  <= pwdata[7:0];
      if (paddr == OFS_CLIP0X) clip0x_reg <= pwdata & CLIP_MASK;
      if (paddr == OFS_CLIP0Y) clip0y_reg <= pwdata & CLIP_MASK;
      if (paddr == OFS_CLIP1X) clip1x_reg <= pwdata & CLIP_MASK;
      if (paddr == OFS_CLIP1Y) clip1y_reg <= pwdata & CLIP_MASK;
    end
  end

  // Working alpha only moves at field end so a field never mixes two values
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) alphaWork_reg <= ALPHA_RESET;
    else if (fieldEnd) alphaWork_reg <= alpha_reg;
  end

  // ****************************************************************
  // Control decode
  // ****************************************************************
  logic [2:0]       decimCode;
  vpp_fmt_e         fmtSel;
  logic             littleEnd, ditherOn, useSet1;
  logic [31:0]      clipX, clipY;
  logic [POS_W-1:0] startX, endX, startY, endY;

  assign decimCode = ctrl_reg[CTL_DECIM_LSB +: 3];
  assign fmtSel    = vpp_fmt_e'(ctrl_reg[CTL_FMT_LSB +: 2]);
  assign littleEnd = ctrl_reg[CTL_LE_BIT];
  assign ditherOn  = CHAN_B ? ctrl_reg[CTL_DITH_B_BIT] : ctrl_reg[CTL_DITH_A_BIT];
  assign useSet1   = fieldOdd_reg ? ctrl_reg[CTL_SEL_OD_BIT] : ctrl_reg[CTL_SEL_EV_BIT];
  assign clipX     = useSet1 ? clip1x_reg : clip0x_reg;
  assign clipY     = useSet1 ? clip1y_reg : clip0y_reg;
  assign startX    = clipX[POS_W-1:0];
  assign endX      = clipX[CLIP_END_LSB +: POS_W];
  assign startY    = clipY[POS_W-1:0];
  assign endY      = clipY[CLIP_END_LSB +: POS_W];

  // ****************************************************************
  // Pair split: one pixel per cycle, chroma repeated for both lumas
  // ****************************************************************
  vpp_pair_s pair_reg;
  logic      held_reg, half_reg;
  logic      pixValid;
  vpp_pix_s  pix;

  assign pairReady = ~held_reg | half_reg;
  assign pixValid  = held_reg;
  assign pix       = '{y: half_reg ? pair_reg.y1 : pair_reg.y0,
                       u: pair_reg.u, v: pair_reg.v};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pair_reg <= '0;
      held_reg <= 1'b0;
      half_reg <= 1'b0;
    end else begin
      if (pairValid && pairReady) pair_reg <= pairData;
      held_reg <= (pairValid && pairReady) | (held_reg & ~half_reg);
      half_reg <= held_reg & ~half_reg;
    end
  end

  // ****************************************************************
  // Clip and decimate
  // ****************************************************************
  logic [POS_W-1:0] xCnt_reg, outLine_reg;
  logic [IDX_W-1:0] outIdx_reg;
  logic [2:0]       hCnt_reg, vCnt_reg;
  logic             lineWin_reg;
  vpp_pix_s         hAcc_reg;
  vpp_pix_s         store [LINE_STORE];
  logic [6:0]       blkArea;
  vpp_pix_s         quot, colSum, vSum, rowPrev;
  logic             inWin, lastCol, lastRow, prevLastRow;
  logic             doStore, doEmit;

  function automatic vpp_pix_s addPix(input vpp_pix_s a, input vpp_pix_s b);
    addPix = '{y: a.y + b.y, u: a.u + b.u, v: a.v + b.v};
  endfunction

  assign blkArea = 7'({4'h0, decimCode} + 7'h01) * 7'({4'h0, decimCode} + 7'h01);
  // Truncating before the sum loses precision at large factors, by design
  assign quot    = '{y: pix.y / blkArea, u: pix.u / blkArea, v: pix.v / blkArea};
  assign inWin   = pixValid && xCnt_reg >= startX && xCnt_reg <= endX
                   && yCnt_reg >= startY && yCnt_reg <= endY;
  // The window edge closes a short block; absent pixels add nothing
  assign lastCol     = (hCnt_reg == decimCode) || (xCnt_reg == endX);
  assign lastRow     = (vCnt_reg == decimCode) || (yCnt_reg == endY);
  assign prevLastRow = lastRow;
  assign colSum  = addPix(hAcc_reg, quot);
  assign rowPrev = (vCnt_reg == 3'h0) ? vpp_pix_s'('0) : store[outIdx_reg];
  assign vSum    = addPix(rowPrev, colSum);
  assign doStore = inWin && lastCol && !lastRow;
  assign doEmit  = inWin && lastCol && lastRow;

  // Line and field counters
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      yCnt_reg     <= '0;
      fieldOdd_reg <= 1'b0;
    end else if (fieldStart) begin
      fieldOdd_reg <= fieldOdd;
      if (!fieldOdd) yCnt_reg <= '0;
    end else if (lineStart) begin
      yCnt_reg <= POS_W'(yCnt_reg + 1'b1);
    end
  end

  // Vertical group position, advanced once per windowed line
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      vCnt_reg    <= 3'h0;
      outLine_reg <= '0;
      lineWin_reg <= 1'b0;
    end else if (fieldStart) begin
      vCnt_reg    <= 3'h0;
      outLine_reg <= '0;
      lineWin_reg <= 1'b0;
    end else if (lineStart) begin
      lineWin_reg <= 1'b0;
      if (lineWin_reg) begin
        vCnt_reg    <= prevLastRow ? 3'h0 : 3'(vCnt_reg + 3'h1);
        outLine_reg <= prevLastRow ? POS_W'(outLine_reg + 1'b1) : outLine_reg;
      end
    end else if (inWin) begin
      lineWin_reg <= 1'b1;
    end
  end

  // Horizontal group position and running column sum
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      xCnt_reg   <= '0;
      hCnt_reg   <= 3'h0;
      outIdx_reg <= '0;
      hAcc_reg   <= '0;
    end else if (lineStart) begin
      xCnt_reg   <= '0;
      hCnt_reg   <= 3'h0;
      outIdx_reg <= '0;
      hAcc_reg   <= '0;
    end else if (pixValid) begin
      xCnt_reg <= POS_W'(xCnt_reg + 1'b1);
      if (inWin) begin
        hCnt_reg   <= lastCol ? 3'h0 : 3'(hCnt_reg + 3'h1);
        hAcc_reg   <= lastCol ? vpp_pix_s'('0) : colSum;
        outIdx_reg <= lastCol ? IDX_W'(outIdx_reg + 1'b1) : outIdx_reg;
      end
    end
  end

  // Partial rows wait in the line store for the next line
  always_ff @(posedge mclk) begin
    if (doStore) store[outIdx_reg] <= vSum;
  end

  // Decimated pixel register
  logic             decValid_reg;
  vpp_pix_s         dec_reg;
  logic [IDX_W-1:0] decX_reg;
  logic [POS_W-1:0] decY_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      decValid_reg <= 1'b0;
      dec_reg      <= '0;
      decX_reg     <= '0;
      decY_reg     <= '0;
    end else begin
      decValid_reg <= doEmit;
      if (doEmit) begin
        dec_reg  <= vSum;
        decX_reg <= outIdx_reg;
        decY_reg <= outLine_reg;
      end
    end
  end

  // ****************************************************************
  // Dither: conversion arithmetic is absent, so V, Y, U stand for R, G, B
  // ****************************************************************
  logic [3:0] thresh;
  logic [2:0] redQ, greenQ, blueQ;
  logic [7:0] rgb8;

  assign thresh = DITHER_M[{decY_reg[1:0], decX_reg[1:0]}];

  vpp_dither #(.BLUE(1'b0)) uRed (
    .compIn  (dec_reg.v),
    .thresh  (thresh),
    .compOut (redQ)
  );
  vpp_dither #(.BLUE(1'b0)) uGreen (
    .compIn  (dec_reg.y),
    .thresh  (thresh),
    .compOut (greenQ)
  );
  vpp_dither #(.BLUE(1'b1)) uBlue (
    .compIn  (dec_reg.u),
    .thresh  (thresh),
    .compOut (blueQ)
  );

  assign rgb8 = {blueQ[1:0], greenQ, redQ};

  // ****************************************************************
  // Pack into 64-bit words
  // ****************************************************************
  logic [63:0] pack_reg, packNext, wordBe, wordLe;
  logic [3:0]  cnt_reg, nBytes, cntNext;
  logic [31:0] pushVal;
  logic        rgbaMode, wordDone;

  assign rgbaMode = (fmtSel == FMT_RGBA || fmtSel == FMT_SPARE) && !ditherOn;

  // Bytes pushed per pixel; the first pushed ends in the top byte
  always_comb begin
    pushVal = 32'h0000_0000;
    nBytes  = BYTES_8BIT;
    if (ditherOn) begin
      pushVal = {24'h00_0000, rgb8};
    end else if (fmtSel == FMT_YUV) begin
      pushVal = {16'h0000, decX_reg[0] ? dec_reg.v : dec_reg.u, dec_reg.y};
      nBytes  = BYTES_YUV;
    end else if (fmtSel == FMT_MONO) begin
      pushVal = {24'h00_0000, dec_reg.y};
    end else begin
      pushVal = {alphaWork_reg, dec_reg.u, dec_reg.y, dec_reg.v};
      nBytes  = BYTES_RGBA;
    end
  end

  assign packNext = (nBytes == BYTES_RGBA) ? {pack_reg[31:0], pushVal}
                  : (nBytes == BYTES_YUV) ? {pack_reg[47:0], pushVal[15:0]}
                  : {pack_reg[55:0], pushVal[7:0]};
  assign cntNext  = 4'(cnt_reg + nBytes);
  assign wordDone = decValid_reg && (cntNext == 4'(WORD_BYTES));
  assign wordBe   = packNext;

  // Full byte reversal for every non-RGBA layout
  always_comb begin
    wordLe = 64'h0;
    for (int i = 0; i < WORD_BYTES; i++) begin
      wordLe[8*i +: 8] = wordBe[8*(WORD_BYTES-1-i) +: 8];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pack_reg  <= 64'h0;
      cnt_reg   <= 4'h0;
      wordValid <= 1'b0;
      wordData  <= 64'h0;
    end else begin
      wordValid <= wordDone;
      if (lineStart) begin
        cnt_reg <= 4'h0;
      end else if (decValid_reg) begin
        pack_reg <= packNext;
        cnt_reg  <= wordDone ? 4'h0 : cntNext;
      end
      if (wordDone) begin
        wordData <= !littleEnd ? wordBe
                  : rgbaMode ? {wordBe[31:0], wordBe[63:32]}
                  : wordLe;
      end
    end
  end

endmodule // vpp_pipeline

// ===== verif/vpp_pipeline_monitor.sv
`timescale 1ns/1ns
// ****************************************************************
// Port checker for the pixel pipeline
// ****************************************************************
module vpp_pipeline_monitor (
  input  wire logic                        mclk,
  input  wire logic                        reset_n,
  input  wire logic [vpp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pready,
  input  wire logic                        pslverr,
  input  wire logic                        pairValid,
  input  wire logic                        pairReady,
  input  wire logic                        wordValid,
  input  wire logic [63:0]                 wordData
);
  import vpp_pkg::*;
  logic [3:0] sinceAcc_reg;
  logic [3:0] sinceAcc_next;
  logic       mapped;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Register hit decode; saturating age of the last accepted pair keeps the count small
  assign mapped        = (paddr[1:0] == 2'h0) && (paddr <= OFS_STATUS);
  assign sinceAcc_next = (pairValid && pairReady) ? 4'h0 :
                         (sinceAcc_reg == 4'hf) ? 4'hf : sinceAcc_reg + 4'h1;
  // Age counter
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) sinceAcc_reg <= 4'hf;
    else sinceAcc_reg <= sinceAcc_next;
  end
  a_pair_pace: assert property (pairValid && pairReady |=> !pairReady)
    else $error("pair input ready right after an accept");
  a_ready_back: assert property (!pairReady |=> pairReady)
    else $error("pair input stalled two cycles");
  a_word_single: assert property (wordValid |=> !wordValid)
    else $error("output words on back-to-back cycles");
  a_word_hold: assert property ($changed(wordData) |-> wordValid)
    else $error("output word changed without a valid pulse");
  a_word_cause: assert property (wordValid |-> sinceAcc_reg <= 4'h8)
    else $error("output word without a recent input pair");
  a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped access not flagged");
  a_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  a_ready_now: assert property (psel && !penable |=> pready)
    else $error("register access not answered at once");
endmodule // vpp_pipeline_monitor

bind vpp_pipeline vpp_pipeline_monitor u_mon (
  .mclk(mclk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .pairValid(pairValid), .pairReady(pairReady),
  .wordValid(wordValid), .wordData(wordData));

// ===== verif/vpp_video_src.sv
`timescale 1ns/1ns
// ****************************************************************
// Decoder side model: framing pulses and 4:2:2 pairs
// ****************************************************************
module vpp_video_src (
  input  wire logic          mclk,
  input  wire logic          pairReady,
  output logic               pairValid,
  output vpp_pkg::vpp_pair_s pairData,
  output logic               lineStart,
  output logic               fieldStart,
  output logic               fieldOdd,
  output logic               fieldEnd
);
  import vpp_pkg::*;
  int stalls = 0;
  // Quiet from time zero
  initial begin
    {pairValid, pairData, lineStart, fieldStart, fieldOdd, fieldEnd} = '0;
  end
  // Field start (with parity) or field end, one cycle wide
  task automatic frame(input logic start, input logic odd);
    if (start) begin
      fieldStart <= 1'b1;
      fieldOdd   <= odd;
    end else fieldEnd <= 1'b1;
    @(posedge mclk);
    {fieldStart, fieldEnd} <= 2'b00;
    @(posedge mclk);
  endtask
  // Line of n pairs; pair i carries base+4i..base+4i+3 as u, y0, v, y1
  task automatic send_line(input int n, input int base);
    int k;
    lineStart <= 1'b1;
    @(posedge mclk);
    lineStart <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      pairValid <= 1'b1;
      pairData  <= {8'(base+4*i), 8'(base+4*i+1), 8'(base+4*i+2), 8'(base+4*i+3)};
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (pairReady !== 1'b1 && k < 20);
      if (k >= 20) stalls++;
    end
    pairValid <= 1'b0;
    pairData  <= ~pairData; // Stale data must never pass for a fresh pair
    repeat (4) @(posedge mclk); // Gap the pipeline needs before the next line start
  endtask
endmodule // vpp_video_src

// ===== verif/tb.sv
`timescale 1ns/1ns
// ****************************************************************
// Self-checking bench for the pixel pipeline
// ****************************************************************
module tb;
  import vpp_pkg::*;
  logic               mclk = 1'b0;
  logic               reset_n = 1'b0;
  logic [7:0]         paddr = '0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [31:0]        pwdata = '0;
  logic [31:0]        prdata;
  logic               pready, pslverr, pairValid, pairReady, wordValid;
  logic               lineStart, fieldStart, fieldOdd, fieldEnd;
  vpp_pair_s          pairData;
  logic [63:0]        wordData;
  logic [63:0]        words[$];
  int                 miscompares = 0;
  int                 numChecks = 0;
  vpp_pipeline #(.CHAN_B(1'b0), .LINE_STORE(384)) DUT (
    .mclk(mclk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pairValid(pairValid), .pairData(pairData), .pairReady(pairReady), .lineStart(lineStart),
    .fieldStart(fieldStart), .fieldOdd(fieldOdd), .fieldEnd(fieldEnd), .wordValid(wordValid),
    .wordData(wordData));
  vpp_video_src src (
    .mclk(mclk), .pairReady(pairReady), .pairValid(pairValid), .pairData(pairData),
    .lineStart(lineStart), .fieldStart(fieldStart), .fieldOdd(fieldOdd), .fieldEnd(fieldEnd));
  // 100 MHz clock; output words are captured where they stand
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (wordValid === 1'b1) words.push_back(wordData);
  // Source bytes of pixel x in a line sent with a given base; chroma shared per pair
  function automatic logic [7:0] yy(int b, int x); return 8'(b + 2 * x + 1); endfunction
  function automatic logic [7:0] uu(int b, int x); return 8'(b + 4 * (x / 2)); endfunction
  function automatic logic [7:0] vv(int b, int x); return 8'(b + 4 * (x / 2) + 2); endfunction
  // Little-endian view: halves swapped for full colour, bytes reversed otherwise
  function automatic logic [63:0] swp(logic [63:0] w, bit rgba);
    logic [63:0] r;
    r = {<<8{w}};
    return rgba ? {w[31:0], w[63:32]} : r;
  endfunction
  // Scaled component stepped up when the remainder beats the threshold
  function automatic logic [2:0] dth(logic [7:0] i, logic [3:0] t, bit blue);
    logic [5:0] sb;
    sb = i[7:2] - 6'(i[7]);
    if (blue) return {1'b0, sb[5:4] + 2'(sb[3:0] > t)};
    return i[7:5] + 3'(i[4:1] > t);
  endfunction
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    miscompares += src.stalls;
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) stop_test();
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge mclk);
  endtask
  // Window set s, then control word; a fresh even field follows
  task automatic setup(input logic [31:0] ctl, input int s, input int xs, xe, ys, ye);
    logic [31:0] d;
    logic        e;
    apb(1'b1, s ? OFS_CLIP1X : OFS_CLIP0X, 32'(xe) << CLIP_END_LSB | 32'(xs), d, e);
    apb(1'b1, s ? OFS_CLIP1Y : OFS_CLIP0Y, 32'(ye) << CLIP_END_LSB | 32'(ys), d, e);
    apb(1'b1, OFS_CTRL, ctl, d, e);
    words.delete();
    src.frame(1'b1, 1'b0);
  endtask
  task automatic expect_words(input int n);
    for (int k = 0; k < 40 && words.size() < n; k++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    chk("word count", 64'(n), 64'(words.size()));
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic        e;
    for (int a = 0; a <= 'h18; a += 4) begin
      apb(1'b0, 8'(a), '0, d, e);
      chk("reset value", 64'h0, {31'h0, e, d});
    end
    apb(1'b1, 8'h1c, 32'hffff_ffff, d, e);
    apb(1'b0, 8'h1c, '0, d, e);
    chk("unmapped", {31'h0, 1'b1, 32'h0}, {31'h0, e, d});
    apb(1'b1, OFS_CLIP0X, 32'hffff_ffff, d, e);
    apb(1'b0, OFS_CLIP0X, '0, d, e);
    chk("clip readback", 64'h03ff_03ff, {31'h0, e, d});
  endtask
  task automatic t_alpha;
    logic [31:0] d;
    logic        e;
    apb(1'b1, OFS_ALPHA, 32'h5a, d, e);
    apb(1'b0, OFS_STATUS, '0, d, e);
    chk("alpha before field end", 64'h0, 64'(d[31:24]));
    src.frame(1'b0, 1'b0);
    apb(1'b0, OFS_STATUS, '0, d, e);
    chk("alpha after field end", 64'h5a, 64'(d[31:24]));
  endtask
  task automatic t_rgba;
    logic [63:0] w0;
    logic [63:0] w1;
    for (int le = 0; le < 2; le++) begin
      setup(32'(le) << CTL_LE_BIT | 32'h1 << CTL_SEL_EV_BIT, 1, 0, 3, 1, 1);
      src.send_line(2, 'h10);
      expect_words(2);
      w0 = {8'h5a, uu(16, 0), yy(16, 0), vv(16, 0), 8'h5a, uu(16, 1), yy(16, 1), vv(16, 1)};
      w1 = {8'h5a, uu(16, 2), yy(16, 2), vv(16, 2), 8'h5a, uu(16, 3), yy(16, 3), vv(16, 3)};
      chk("rgba word 0", le ? swp(w0, 1) : w0, words[0]);
      chk("rgba word 1", le ? swp(w1, 1) : w1, words[1]);
    end
  endtask
  task automatic t_yuv;
    logic [63:0] w;
    for (int le = 0; le < 2; le++) begin
      setup(32'(le) << CTL_LE_BIT | 32'h1 << CTL_FMT_LSB, 0, 0, 3, 1, 1);
      src.send_line(2, 'h40);
      expect_words(1);
      w = {uu(64, 0), yy(64, 0), vv(64, 0), yy(64, 1), uu(64, 2), yy(64, 2), vv(64, 2), yy(64, 3)};
      chk("yuv word", le ? swp(w, 0) : w, words[0]);
    end
  endtask
  // Ten pixels of line 2 pass; the two beyond a whole word are dropped
  task automatic t_clip;
    logic [63:0] w;
    setup(32'h2 << CTL_FMT_LSB, 0, 2, 11, 2, 2);
    src.send_line(6, 'h20);
    src.send_line(6, 'h80);
    src.send_line(1, 'h00);
    expect_words(1);
    for (int k = 0; k < 8; k++) w[63-8*k -: 8] = yy('h80, k + 2);
    chk("clipped word", w, words[0]);
  endtask
  // Factor 1/2 over a 15-pixel window: the last block lacks a column
  task automatic t_decim;
    logic [63:0] w;
    setup(32'h1 | 32'h2 << CTL_FMT_LSB, 0, 0, 14, 1, 2);
    src.send_line(8, 'h30);
    src.send_line(8, 'h90);
    expect_words(1);
    for (int k = 0; k < 8; k++)
      w[63-8*k -: 8] = yy('h30, 2*k) / 4 + yy('h90, 2*k) / 4 +
                       (k < 7 ? yy('h30, 2*k+1) / 4 + yy('h90, 2*k+1) / 4 : 8'h0);
    chk("decimated word", w, words[0]);
  endtask
  task automatic t_dither;
    logic [63:0] w;
    logic [3:0]  t;
    setup(32'h1 << CTL_DITH_A_BIT | 32'h2 << CTL_FMT_LSB, 0, 0, 7, 1, 1);
    src.send_line(4, 'hb7);
    expect_words(1);
    for (int k = 0; k < 8; k++) begin
      t = DITHER_M[k % 4];
      w[63-8*k -: 8] = {2'(dth(uu('hb7, k), t, 1'b1)), dth(yy('hb7, k), t, 1'b0),
                        dth(vv('hb7, k), t, 1'b0)};
    end
    chk("dithered word", w, words[0]);
  endtask
  // Reset for five cycles, then every scenario in turn
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_alpha();
    t_rgba();
    t_yuv();
    t_clip();
    t_decim();
    t_dither();
    stop_test();
  end
endmodule // tb
